// ---- cwd_pkg.sv ----
/*
  package for the configuration word decoder: word indices, implemented
  bit masks, erased values, field positions and the decoded carrier.
  assumes a 32-bit register port with word-sized configuration images.
*/
package cwd_pkg;

  // ----------------------------------------------------------------------
  // register map (word index on the plain register port)
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 3;
  localparam logic [2:0] OFS_WD_CFG     = 3'h0;
  localparam logic [2:0] OFS_POR_CFG    = 3'h1;
  localparam logic [2:0] OFS_DBG_CFG    = 3'h2;
  localparam logic [2:0] OFS_DMWIN_LO   = 3'h3;
  localparam logic [2:0] OFS_DMWIN_HI   = 3'h4;
  localparam logic [2:0] OFS_DMCNT_LO   = 3'h5;
  localparam logic [2:0] OFS_STATUS     = 3'h6;
  localparam int unsigned NUM_WORDS = 6;

  // ----------------------------------------------------------------------
  // implemented bits and erased values of each 24-bit word
  // ----------------------------------------------------------------------
  localparam logic [23:0] MASK_WD_CFG  = 24'h006BFF;
  localparam logic [23:0] MASK_POR_CFG = 24'h00000F;
  localparam logic [23:0] MASK_DBG_CFG = 24'h0000A3;
  localparam logic [23:0] MASK_DM16    = 24'h00FFFF;
  localparam logic [23:0] ERASED_WORD  = 24'hFFFFFF;
  localparam logic [23:0] ERASED_DBG   = 24'hFFFFDF;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned WD_CLK_LSB   = 13;
  localparam int unsigned WD_CMX_BIT   = 11;
  localparam int unsigned WD_WIN_LSB   = 8;
  localparam int unsigned WD_WDIS_BIT  = 7;
  localparam int unsigned WD_EN_LSB    = 5;
  localparam int unsigned WD_PSA_BIT   = 4;
  localparam int unsigned WD_PS_LSB    = 0;
  localparam int unsigned POR_DNVP_BIT = 3;
  localparam int unsigned POR_LPCF_BIT = 2;
  localparam int unsigned POR_BOR_LSB  = 0;
  localparam int unsigned DBG_SCAN_BIT = 5;
  localparam int unsigned DBG_CH_LSB   = 0;

  // ----------------------------------------------------------------------
  // decoded constants
  // ----------------------------------------------------------------------
  localparam logic [2:0] PRESCALE_LOG2_HI = 3'h7;   // 1:128
  localparam logic [2:0] PRESCALE_LOG2_LO = 3'h5;   // 1:32
  localparam logic [2:0] WIN_EIGHTHS_25   = 3'h2;
  localparam logic [2:0] WIN_EIGHTHS_375  = 3'h3;
  localparam logic [2:0] WIN_EIGHTHS_50   = 3'h4;
  localparam logic [2:0] WIN_EIGHTHS_75   = 3'h6;

  // watchdog clock source, one-hot
  typedef enum logic [3:0] {
    CWD_SRC_LOW_POWER_RC_OSC   = 4'h1,
    CWD_SRC_SECONDARY_OSC   = 4'h2,
    CWD_SRC_FRC    = 4'h4,
    CWD_SRC_PERIPH = 4'h8
  } cwd_src_t;

  // captured configuration fields
  typedef struct packed {
    logic        wd_clock_mux_enable;
    logic [1:0]  wd_clock_select;
    logic [1:0]  wd_window_width;
    logic        window_mode_disable;
    logic [1:0]  wd_enable_mode;
    logic        wd_prescale_select;
    logic [3:0]  wd_postscale_select;
    logic        downside_protect_enable;
    logic        low_power_regulator_control;
    logic [1:0]  brownout_enable_mode;
    logic        scan_port_enable;
    logic [1:0]  debug_channel_select;
    logic [31:0] deadman_window_interval;
    logic [15:0] deadman_count_limit_low;
  } cwd_cfg_t;

  localparam cwd_cfg_t CFG_ERASED = '{
    scan_port_enable: 1'b0,
    default: '1
  };

endpackage : cwd_pkg

// ---- cwd_decode.sv ----
/*
  configuration word decoder: holds the program-once configuration words,
  captures them across a device reset and drives the decoded watchdog,
  brown-out, debug and deadman settings.
  assumes runtime status pins come from other clock domains and that the
  register port master obeys single-cycle strobes.
*/
// Operation
// (R1) every stored bit erases to one, scan enable erases to zero
// (R2) unimplemented watchdog word bits always read back as one
// (R3) mux disabled means low-power rc; enabled means clock select decides
// (R4) select 11 gives low-power rc, 01 gives secondary oscillator
// (R5) select 10 gives fast rc if windowed, sysclk not low_power_rc_osc, awake
// (R6) select 00 gives peripheral clock if sysclk not low_power_rc_osc and awake
// (R7) window width 11/10/01/00 gives 25/37.5/50/75 percent
// (R8) window disable one turns windowed mode off, zero turns it on
// (R9) enable 11 forces watchdog on; 10 hands control to software bit
// (R10) enable 01 runs only awake ignoring software; 00 disables all
// (R11) prescaler bit selects divide by 128 when set, 32 when clear
// (R12) postscale divides by two to the power of the field
// (R13) downside protection follows its bit while brown-out is inactive
// (R14) regulator bit one blocks retention; zero lets runtime bit decide
// (R15) brown-out 11 forces on, 00 forces off, software bit ignored
// (R16) brown-out 10 on only while awake; 01 follows software bit
// (R17) scan port enable bit turns the scan port on or off
// (R18) channel select picks pin pair 1, 2 or 3; 00 is reserved
// (R19) programmer keeps reserved debug word bit 7 at one
// (R20) deadman window interval is 32 bits from low and high words
// (R21) low 16 deadman count limit bits come from bits 15 to 0
// (R22) upper deadman count limit bits live in a separate word
// (R23) decoded values captured during reset and held until next reset
`timescale 1ns/10ps
module cwd_decode
  import cwd_pkg::*;
#(
  parameter int unsigned SYNC_W = 6
) (
  input  wire logic                        SYS_CLK,
  input  wire logic                        RST_B,
  input  wire logic [cwd_pkg::ADDR_W-1:0]  ADDR,
  input  wire logic [31:0]                 WDATA,
  input  wire logic                        WR_STB,
  input  wire logic                        RD_STB,
  output logic      [31:0]                 RDATA,
  input  wire logic                        DEV_RESET,
  input  wire logic                        SLEEPING,
  input  wire logic                        SYSCLK_IS_LOW_POWER_RC_OSC,
  input  wire logic                        SOFTWARE_WD_ENABLE,
  input  wire logic                        SOFTWARE_BROWNOUT_ENABLE,
  input  wire logic                        RETENTION_ENABLE,
  output logic                             WD_ON,
  output cwd_pkg::cwd_src_t                WD_CLK_SRC,
  output logic                             WD_WINDOW_ON,
  output logic      [2:0]                  WD_WINDOW_EIGHTHS,
  output logic      [2:0]                  WD_PRESCALE_LOG2,
  output logic      [3:0]                  WD_POSTSCALE_LOG2,
  output logic                             BROWNOUT_ON,
  output logic                             DOWNSIDE_PROTECT_ON,
  output logic                             RETENTION_ON,
  output logic                             SCAN_PORT_ON,
  output logic      [2:0]                  DEBUG_PIN_PAIR,
  output logic                             DEBUG_CH_RESERVED,
  output logic      [31:0]                 DEADMAN_WINDOW,
  output logic      [15:0]                 DEADMAN_COUNT_LOW
);
  import cwd_pkg::*;

  // ----------------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------------
  logic [1:0] rst_sync_q;
  logic       rst_n;

  // async assert, two-flop release keeps the release edge clean;
  // nothing below reads RST_B itself, only the released copy,
  // so every flop leaves reset on the same edge
  always_ff @(posedge SYS_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic              dev_rst_s;
  logic              sleep_s;
  logic              sys_low_power_rc_osc_s;
  logic              sw_wd_s;
  logic              sw_bor_s;
  logic              retention_enable_s;

  assign pin_raw = {DEV_RESET, SLEEPING, SYSCLK_IS_LOW_POWER_RC_OSC,
                    SOFTWARE_WD_ENABLE, SOFTWARE_BROWNOUT_ENABLE,
                    RETENTION_ENABLE};

  // runtime pins are slow levels from other domains, so one
  // two-flop chain per bit will do; no multi-bit word crosses
  // first stage feeds only the second stage
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  assign {dev_rst_s, sleep_s, sys_low_power_rc_osc_s,
          sw_wd_s, sw_bor_s, retention_enable_s} = sync2_q;

  // ----------------------------------------------------------------------
  // program-once word store
  // ----------------------------------------------------------------------
  // word 0 watchdog, 1 power-on, 2 debug, 3/4 deadman window
  // low/high, 5 deadman count low; flops stand in for the
  // program-once array, so every power-on reset erases them
  logic [23:0]          word_q    [NUM_WORDS];
  logic [NUM_WORDS-1:0] written_q;
  logic [23:0]          word_mask [NUM_WORDS];
  logic [NUM_WORDS-1:0] wr_hit;

  assign word_mask[0] = MASK_WD_CFG;
  assign word_mask[1] = MASK_POR_CFG;
  assign word_mask[2] = MASK_DBG_CFG;
  assign word_mask[3] = MASK_DM16;
  assign word_mask[4] = MASK_DM16;
  assign word_mask[5] = MASK_DM16;

  // each word accepts one programming write, then locks
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WORDS; gi++) begin : g_word
      assign wr_hit[gi] = WR_STB && !written_q[gi] &&
                          (ADDR == ADDR_W'(gi));
      always_ff @(posedge SYS_CLK or negedge rst_n) begin
        if (!rst_n) begin
          word_q[gi]    <= (gi == 2) ? ERASED_DBG : ERASED_WORD; // [R1]
          written_q[gi] <= 1'b0;
        end else if (wr_hit[gi]) begin
          // unimplemented positions stay one whatever is written
          word_q[gi]    <= WDATA[23:0] | ~word_mask[gi];       // [R2]
          written_q[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // field extraction from the stored words
  // ----------------------------------------------------------------------
  cwd_cfg_t cfg_now;
  cwd_cfg_t cfg_q;
  logic     load_pend_q;
  logic     capture;

  assign cfg_now.wd_clock_mux_enable     = word_q[0][WD_CMX_BIT];
  assign cfg_now.wd_clock_select         = word_q[0][WD_CLK_LSB +: 2];
  assign cfg_now.wd_window_width         = word_q[0][WD_WIN_LSB +: 2];
  assign cfg_now.window_mode_disable     = word_q[0][WD_WDIS_BIT];
  assign cfg_now.wd_enable_mode          = word_q[0][WD_EN_LSB +: 2];
  assign cfg_now.wd_prescale_select      = word_q[0][WD_PSA_BIT];
  assign cfg_now.wd_postscale_select     = word_q[0][WD_PS_LSB +: 4];
  assign cfg_now.downside_protect_enable = word_q[1][POR_DNVP_BIT];
  assign cfg_now.low_power_regulator_control = word_q[1][POR_LPCF_BIT];
  assign cfg_now.brownout_enable_mode    = word_q[1][POR_BOR_LSB +: 2];
  assign cfg_now.scan_port_enable        = word_q[2][DBG_SCAN_BIT];
  assign cfg_now.debug_channel_select    = word_q[2][DBG_CH_LSB +: 2];
  // window: high word above low word
  assign cfg_now.deadman_window_interval = {word_q[4][15:0],
                                            word_q[3][15:0]};   // [R20]
  assign cfg_now.deadman_count_limit_low = word_q[5][15:0];    // [R21]

  // ----------------------------------------------------------------------
  // capture across device reset
  // ----------------------------------------------------------------------
  // capture while the device reset is held and once after power-up;
  // in between the words may be programmed but nothing downstream moves
  // only cfg_q feeds the decode, so a late write can never
  // disturb a running watchdog or brown-out setting
  assign capture = load_pend_q || dev_rst_s;                   // [R23]

  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      load_pend_q <= 1'b1;
      cfg_q       <= CFG_ERASED;                               // [R1]
    end else begin
      load_pend_q <= 1'b0;
      if (capture) begin
        cfg_q <= cfg_now;                                      // [R23]
      end
    end
  end

  // ----------------------------------------------------------------------
  // watchdog decode
  // ----------------------------------------------------------------------
  logic     window_on;
  logic     fast_ok;
  logic     periph_ok;
  cwd_src_t src_sel;
  cwd_src_t src_d;
  logic     wd_on_d;
  logic [2:0] win_d;

  assign window_on = !cfg_q.window_mode_disable;               // [R8]
  assign fast_ok   = window_on && !sys_low_power_rc_osc_s && !sleep_s;     // [R5]
  assign periph_ok = !sys_low_power_rc_osc_s && !sleep_s;                  // [R6]

  // source one-hot: low_power_rc_osc 1, secondary_osc 2, frc 4, peripheral 8;
  // sleep or an low_power_rc_osc system clock pulls fast sources back
  // clock select only matters with the mux on
  always_comb begin
    unique case (cfg_q.wd_clock_select)
      2'b11:   src_sel = CWD_SRC_LOW_POWER_RC_OSC;                         // [R4]
      2'b01:   src_sel = CWD_SRC_SECONDARY_OSC;                         // [R4]
      2'b10:   src_sel = fast_ok ? CWD_SRC_FRC : CWD_SRC_LOW_POWER_RC_OSC; // [R5]
      2'b00:   src_sel = periph_ok ? CWD_SRC_PERIPH
                                   : CWD_SRC_LOW_POWER_RC_OSC;             // [R6]
      default: src_sel = CWD_SRC_LOW_POWER_RC_OSC;
    endcase
  end
  assign src_d = cfg_q.wd_clock_mux_enable ? src_sel
                                           : CWD_SRC_LOW_POWER_RC_OSC;     // [R3]

  // enable modes: forced, software, awake-only, off
  // the software pin counts only in its own mode
  always_comb begin
    unique case (cfg_q.wd_enable_mode)
      2'b11:   wd_on_d = 1'b1;                                 // [R9]
      2'b10:   wd_on_d = sw_wd_s;                              // [R9]
      2'b01:   wd_on_d = !sleep_s;                             // [R10]
      default: wd_on_d = 1'b0;                                 // [R10]
    endcase
  end

  // open window in eighths of the period
  // only 2, 3, 4 or 6 eighths can come out
  always_comb begin
    unique case (cfg_q.wd_window_width)
      2'b11:   win_d = WIN_EIGHTHS_25;                         // [R7]
      2'b10:   win_d = WIN_EIGHTHS_375;                        // [R7]
      2'b01:   win_d = WIN_EIGHTHS_50;                         // [R7]
      default: win_d = WIN_EIGHTHS_75;                         // [R7]
    endcase
  end

  // ----------------------------------------------------------------------
  // brown-out, regulator and debug decode
  // ----------------------------------------------------------------------
  logic       bor_d;
  logic       dnvp_d;
  logic       retention_enable_d;
  logic [2:0] pair_d;
  logic       ch_bad;

  // 11 on, 10 awake only, 01 software pin, 00 off
  always_comb begin
    unique case (cfg_q.brownout_enable_mode)
      2'b11:   bor_d = 1'b1;                                   // [R15]
      2'b10:   bor_d = !sleep_s;                               // [R16]
      2'b01:   bor_d = sw_bor_s;                               // [R16]
      default: bor_d = 1'b0;                                   // [R15]
    endcase
  end

  // downside protection only acts while brown-out is idle
  assign dnvp_d  = !bor_d && cfg_q.downside_protect_enable;    // [R13]
  // retention is a sleep feature gated by the regulator bit
  assign retention_enable_d = !cfg_q.low_power_regulator_control &&
                   retention_enable_s && sleep_s;                         // [R14]

  // reserved code falls back to pair 1 so debug is never lost
  // pair one-hot: bit 0 pair 1, bit 1 pair 2, bit 2 pair 3
  assign ch_bad = (cfg_q.debug_channel_select == 2'b00);       // [R18]
  always_comb begin
    unique case (cfg_q.debug_channel_select)
      2'b10:   pair_d = 3'b010;                                // [R18]
      2'b01:   pair_d = 3'b100;                                // [R18]
      default: pair_d = 3'b001;                                // [R18]
    endcase
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  // every output leaves a flop; a runtime pin reaches it three
  // edges after it moves (two sync flops and this stage)
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      WD_ON               <= 1'b0;
      WD_CLK_SRC          <= CWD_SRC_LOW_POWER_RC_OSC;
      WD_WINDOW_ON        <= 1'b0;
      WD_WINDOW_EIGHTHS   <= WIN_EIGHTHS_25;
      WD_PRESCALE_LOG2    <= PRESCALE_LOG2_HI;
      WD_POSTSCALE_LOG2   <= 4'hF;
      BROWNOUT_ON         <= 1'b0;
      DOWNSIDE_PROTECT_ON <= 1'b0;
      RETENTION_ON        <= 1'b0;
      SCAN_PORT_ON        <= 1'b0;
      DEBUG_PIN_PAIR      <= 3'b001;
      DEBUG_CH_RESERVED   <= 1'b0;
      DEADMAN_WINDOW      <= '1;
      DEADMAN_COUNT_LOW   <= '1;
    end else begin
      WD_ON               <= wd_on_d;
      WD_CLK_SRC          <= src_d;
      WD_WINDOW_ON        <= window_on;                        // [R8]
      WD_WINDOW_EIGHTHS   <= win_d;
      WD_PRESCALE_LOG2    <= cfg_q.wd_prescale_select
                             ? PRESCALE_LOG2_HI
                             : PRESCALE_LOG2_LO;               // [R11]
      WD_POSTSCALE_LOG2   <= cfg_q.wd_postscale_select;        // [R12]
      BROWNOUT_ON         <= bor_d;
      DOWNSIDE_PROTECT_ON <= dnvp_d;
      RETENTION_ON        <= retention_enable_d;
      SCAN_PORT_ON        <= cfg_q.scan_port_enable;           // [R17]
      DEBUG_PIN_PAIR      <= pair_d;
      DEBUG_CH_RESERVED   <= ch_bad;
      DEADMAN_WINDOW      <= cfg_q.deadman_window_interval;    // [R20]
      DEADMAN_COUNT_LOW   <= cfg_q.deadman_count_limit_low;    // [R21]
    end
  end

  // ----------------------------------------------------------------------
  // register read path
  // ----------------------------------------------------------------------
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic        rd_word;

  // live view of what the decoded outputs are doing:
  //   [0]     watchdog running
  //   [1]     windowed mode
  //   [5:2]   watchdog clock source
  //   [6]     brown-out reset active
  //   [7]     downside protection
  //   [8]     retention
  //   [9]     scan port
  //   [12:10] debug pin pair
  //   [13]    reserved channel code
  //   [19:14] written flags, word 0 lowest
  //   [31:20] zero
  assign status_word = {12'h000, written_q, DEBUG_CH_RESERVED,
                        DEBUG_PIN_PAIR, SCAN_PORT_ON, RETENTION_ON,
                        DOWNSIDE_PROTECT_ON, BROWNOUT_ON, WD_CLK_SRC,
                        WD_WINDOW_ON, WD_ON};
  assign rd_word = (ADDR < ADDR_W'(NUM_WORDS));

  // limitation: reads show the stored image, not the captured
  // one, so a write is visible here before any device reset
  // words read back in the low 24 bits; unmapped reads give zero
  assign rd_mux = rd_word ? {8'h00, word_q[ADDR]}              // [R2]
                : (ADDR == OFS_STATUS) ? status_word : 32'h0000_0000;

  // data stand only in the cycle after the strobe
  always_ff @(posedge SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      RDATA <= 32'h0000_0000;
    end else begin
      RDATA <= RD_STB ? rd_mux : 32'h0000_0000;
    end
  end

endmodule : cwd_decode

// ---- cwd_decode_properties.sv ----
/*
  port checker for the configuration word decoder.
  assumes a bind onto cwd_decode with ports joined by name.
*/
`timescale 1ns/10ps
module cwd_checker
  import cwd_pkg::*;
(
  input wire logic                      SYS_CLK,
  input wire logic                      RST_B,
  input wire logic [cwd_pkg::ADDR_W-1:0] ADDR,
  input wire logic                      RD_STB,
  input wire logic [31:0]               RDATA,
  input wire logic                      DEV_RESET,
  input wire logic                      SLEEPING,
  input wire cwd_pkg::cwd_src_t         WD_CLK_SRC,
  input wire logic                      WD_WINDOW_ON,
  input wire logic [2:0]                WD_WINDOW_EIGHTHS,
  input wire logic [2:0]                WD_PRESCALE_LOG2,
  input wire logic                      BROWNOUT_ON,
  input wire logic                      DOWNSIDE_PROTECT_ON,
  input wire logic                      RETENTION_ON,
  input wire logic [2:0]                DEBUG_PIN_PAIR,
  input wire logic                      DEBUG_CH_RESERVED,
  input wire logic [31:0]               DEADMAN_WINDOW
);
  // ------------------------------------------------------------
  // one clock domain, so one default clocking and disable
  // ------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);

  // read port and decode codes
  rd_back_a: assert property (
    RD_STB && ADDR == OFS_WD_CFG |=> RDATA[31:24] == 8'h00
      && (RDATA[23:0] | MASK_WD_CFG) == 24'hFFFFFF)
    else $error("unused watchdog bits read low");
  clk_onehot_a: assert property ($onehot(WD_CLK_SRC))
    else $error("watchdog clock source not one-hot");
  frc_window_a: assert property (
    WD_CLK_SRC == CWD_SRC_FRC |-> WD_WINDOW_ON)
    else $error("fast rc chosen outside windowed mode");
  window_code_a: assert property (
    WD_WINDOW_EIGHTHS inside {3'h2, 3'h3, 3'h4, 3'h6})
    else $error("window width code out of set");
  prescale_code_a: assert property (
    WD_PRESCALE_LOG2 inside {3'h5, 3'h7})
    else $error("prescale code out of set");

  // sync delay of runtime pins is covered by eight steady samples
  sleep_src_a: assert property (
    SLEEPING [*8] |-> !(WD_CLK_SRC inside {CWD_SRC_FRC, CWD_SRC_PERIPH}))
    else $error("fast clock source kept in sleep");
  awake_ret_a: assert property (
    (!SLEEPING) [*8] |-> !RETENTION_ON)
    else $error("retention on while awake");
  downside_bor_a: assert property (
    DOWNSIDE_PROTECT_ON |-> !BROWNOUT_ON)
    else $error("downside protection with brown-out on");
  pair_code_a: assert property (
    $onehot(DEBUG_PIN_PAIR) && (!DEBUG_CH_RESERVED || DEBUG_PIN_PAIR == 3'h1))
    else $error("debug pin pair code bad");
  hold_cfg_a: assert property (
    (!DEV_RESET) [*8] |-> $stable(DEADMAN_WINDOW))
    else $error("deadman window moved outside reset");

  cover property (RETENTION_ON);
  cover property (WD_CLK_SRC == CWD_SRC_FRC);
  cover property (DEBUG_CH_RESERVED);
endmodule : cwd_checker

// ---- tb_config_word_decode.sv ----
/*
  bench for the configuration word decoder: random words, program-once,
  read-back and decode after a device reset pulse.
  assumes cwd_pkg and the checker file are compiled first.
*/
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
  err_total++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module tb_config_word_decode
  import cwd_pkg::*;
;
  logic             SYS_CLK, RST_B, WR_STB, RD_STB, DEV_RESET;
  logic             snap = 1'b0;
  logic             rd_d = 1'b0;
  logic [2:0]       ADDR;
  logic [31:0]      WDATA;
  logic [4:0]       pins;  // sleep, sysclk low_power_rc_osc, sw wd, sw bor, retention
  logic [15:0]      lf = 16'hBEDA;
  logic [23:0]      w [6];
  logic [23:0]      d;
  logic [7:0]       b;
  logic [71:0]      q [$];
  logic [71:0]      n, e0;
  int               err_total = 0;
  int               checked = 0;
  wire logic [31:0] RDATA, DEADMAN_WINDOW;
  wire logic [15:0] DEADMAN_COUNT_LOW;
  wire logic [3:0]  WD_POSTSCALE_LOG2;
  wire logic [2:0]  WD_WINDOW_EIGHTHS, WD_PRESCALE_LOG2, DEBUG_PIN_PAIR;
  wire cwd_src_t    WD_CLK_SRC;
  wire logic        WD_ON, WD_WINDOW_ON, BROWNOUT_ON, DOWNSIDE_PROTECT_ON;
  wire logic        RETENTION_ON, SCAN_PORT_ON, DEBUG_CH_RESERVED;
  wire logic [71:0] obs = {WD_ON, WD_CLK_SRC, WD_WINDOW_ON,
    WD_WINDOW_EIGHTHS, WD_PRESCALE_LOG2, WD_POSTSCALE_LOG2, BROWNOUT_ON,
    DOWNSIDE_PROTECT_ON, RETENTION_ON, SCAN_PORT_ON, DEBUG_PIN_PAIR,
    DEBUG_CH_RESERVED, DEADMAN_WINDOW, DEADMAN_COUNT_LOW};
  localparam logic [23:0] MSK [6] = '{MASK_WD_CFG, MASK_POR_CFG,
    MASK_DBG_CFG, MASK_DM16, MASK_DM16, MASK_DM16};

  cwd_decode DUT (.SLEEPING(pins[4]), .SYSCLK_IS_LOW_POWER_RC_OSC(pins[3]),
    .SOFTWARE_WD_ENABLE(pins[2]), .SOFTWARE_BROWNOUT_ENABLE(pins[1]),
    .RETENTION_ENABLE(pins[0]), .*);

  // ------------------------------------------------------------
  // reference decode and stimulus helpers
  // ------------------------------------------------------------
  function automatic logic [71:0] model(input logic [23:0] v [6],
                                        input logic [4:0] p);
    logic       sl, won, wd, bor;
    logic [3:0] src;
    logic [2:0] e8, pr;
    sl  = p[4];
    won = !v[0][7];
    wd  = v[0][6] ? (v[0][5] | p[2]) : (v[0][5] & !sl);
    bor = v[1][1] ? (v[1][0] | !sl) : (v[1][0] & p[1]);
    if (!v[0][11] || v[0][14:13] == 2'h3) src = 4'h1;
    else if (v[0][14:13] == 2'h1) src = 4'h2;
    else if (v[0][14:13] == 2'h2) src = (won && !p[3] && !sl) ? 4'h4 : 4'h1;
    else src = (!p[3] && !sl) ? 4'h8 : 4'h1;
    e8 = (v[0][9:8] == 2'h0) ? 3'h6 : 3'h5 - {1'b0, v[0][9:8]};
    pr = (v[2][1:0] == 2'h2) ? 3'h2 : (v[2][1:0] == 2'h1) ? 3'h4 : 3'h1;
    return {wd, src, won, e8, v[0][4] ? 3'h7 : 3'h5, v[0][3:0], bor,
      v[1][3] & !bor, !v[1][2] & p[0] & sl, v[2][5], pr,
      v[2][1:0] == 2'h0, v[4][15:0], v[3][15:0], v[5][15:0]};
  endfunction : model

  function automatic logic [7:0] rnd8();
    for (int i = 0; i < 8; i++)
      lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
    return lf[7:0];
  endfunction : rnd8

  task automatic wr(input logic [2:0] a, input logic [23:0] v);
    @(posedge SYS_CLK);
    ADDR   <= a;
    WDATA  <= {8'h00, v};
    WR_STB <= 1'b1;
    @(posedge SYS_CLK);
    WR_STB <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    q.push_back({40'h0, e});
    @(posedge SYS_CLK);
    ADDR   <= a;
    RD_STB <= 1'b1;
    @(posedge SYS_CLK);
    RD_STB <= 1'b0;
  endtask : rd

  task automatic look(input logic [71:0] e);
    q.push_back(e);
    @(posedge SYS_CLK);
    snap <= 1'b1;
    @(posedge SYS_CLK);
    snap <= 1'b0;
  endtask : look

  task automatic close_out();
    if (err_total == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : close_out

  // ------------------------------------------------------------
  // clock, monitor, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  // notes leave the queue in the order the driver queued them
  always @(posedge SYS_CLK) rd_d <= RD_STB;
  always @(negedge SYS_CLK) begin
    if (rd_d) begin
      n = q.pop_front();
      `CHK("read data", n, {40'h0, RDATA})
    end
    if (snap) begin
      n = q.pop_front();
      `CHK("decoded outputs", n, obs)
    end
  end

  // a hang costs one mismatch and ends the run
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    err_total++;
    close_out();
  end

  // each pass: fresh reset, random pins and words, device reset pulse
  initial begin
    {RST_B, WR_STB, RD_STB, DEV_RESET, ADDR, WDATA, pins} = '0;
    repeat (16) @(posedge SYS_CLK);
    for (int it = 0; it < 24; it++) begin
      RST_B <= 1'b0;
      b = rnd8();
      pins <= b[4:0];
      for (int k = 0; k < 6; k++)
        w[k] = (k == 2) ? ERASED_DBG : ERASED_WORD;
      repeat (2) @(posedge SYS_CLK);
      RST_B <= 1'b1;
      repeat (8) @(posedge SYS_CLK);
      e0 = model(w, pins);
      look(e0);
      for (int k = 0; k < 6; k++) begin
        d = {rnd8(), rnd8(), rnd8()};
        if (k == 2) d[7] = 1'b1;
        wr(3'(k), d);
        wr(3'(k), ~d);
        w[k] = (d & MSK[k]) | ~MSK[k];
        rd(3'(k), {8'h00, w[k]});
      end
      rd(3'h7, 32'h0);
      rd(OFS_STATUS, {12'h0, 6'h3F, e0[48], e0[51:49], e0[52],
        e0[53], e0[54], e0[55], e0[70:66], e0[71]});
      look(e0);
      @(posedge SYS_CLK);
      DEV_RESET <= 1'b1;
      repeat (2) @(posedge SYS_CLK);
      DEV_RESET <= 1'b0;
      repeat (6) @(posedge SYS_CLK);
      look(model(w, pins));
    end
    close_out();
  end
endmodule : tb_config_word_decode

bind cwd_decode cwd_checker u_chk (.*);
